//--- include/fuc_params.svh
// Constants of the flash update command slave: codes, block map, timing
`ifndef FUC_PARAMS_SVH
`define FUC_PARAMS_SVH

// Handshake and command bytes
`define FUC_BYTE_OK       8'h00
`define FUC_BYTE_NG       8'h01
`define FUC_BYTE_REQ      8'h11
`define FUC_BYTE_START    8'h55
`define FUC_BYTE_ERASE    8'h77
`define FUC_BYTE_PROG     8'h88
// Sent in a frame when no reply is pending
`define FUC_BYTE_IDLE     8'hFF

// Character width on the link
`define FUC_CHAR_BITS     8

// Erase block map: four small blocks, then one large block
`define FUC_NUM_BLOCKS    5
`define FUC_EB0_BASE      15'h0000
`define FUC_EB1_BASE      15'h0400
`define FUC_EB2_BASE      15'h0800
`define FUC_EB3_BASE      15'h0C00
`define FUC_EB4_BASE      15'h1000
`define FUC_FLASH_TOP     15'h7FFF
// One past the last flash byte, for range checks
`define FUC_FLASH_END     17'h0_8000

// Timing: link bit rate and system clock
`define FUC_BIT_KBPS      250
`define FUC_CLK_NS        10
`define FUC_BIT_NS        (1000000 / `FUC_BIT_KBPS)
`define FUC_BIT_CYCLES    (`FUC_BIT_NS / `FUC_CLK_NS)
// Silence of this many characters aborts a transfer
`define FUC_TMO_CHARS     64
`define FUC_TMO_CYCLES    (`FUC_TMO_CHARS * `FUC_CHAR_BITS * `FUC_BIT_CYCLES)
// Cycles spent copying the program/erase routine into RAM
`define FUC_COPY_CYCLES   256

`endif

//--- include/fuc_pkg.sv
// Types of the flash update command slave
package fuc_pkg;

  // Command interpreter states
  typedef enum logic [3:0] {
    ST_NORMAL,
    ST_COPY,
    ST_CMD,
    ST_ERASE_SEL,
    ST_ERASE,
    ST_ERASE_WAIT,
    ST_PROG_HDR,
    ST_PROG_DATA,
    ST_PROG_WAIT,
    ST_FINISH
  } fuc_state_t;

  // Request to the flash array controller
  typedef struct packed {
    logic        erase;
    logic        write;
    logic [14:0] addr;
    logic [14:0] limit;
    logic [7:0]  data;
  } fuc_flash_req_t;

  // Answer from the flash array controller
  typedef struct packed {
    logic done;
    logic fail;
  } fuc_flash_rsp_t;

  // State of the link-clock shifter
  typedef struct packed {
    logic       rs1;
    logic       rs2;
    logic       t1;
    logic       t2;
    logic       t3;
    logic       pend;
    logic       ld;
    logic [2:0] cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic       rx_tog;
    logic [7:0] tx_sh;
    logic [7:0] tx_next;
  } fuc_link_t;

  // State of the system-clock interpreter
  typedef struct packed {
    fuc_state_t     st;
    logic           s1;
    logic           s2;
    logic           s3;
    logic [7:0]     tx_hold;
    logic           tx_tog;
    logic [15:0]    addr;
    logic [15:0]    left;
    logic [1:0]     hdr;
    logic [4:0]     mask;
    logic [2:0]     blk;
    logic [15:0]    cnt;
    logic [17:0]    tmr;
    logic           done_pin;
    logic           busy_pin;
    logic           app_run;
    logic           copy_act;
    logic           ram_exec;
    logic           updated;
    fuc_flash_req_t fl;
  } fuc_sys_t;

endpackage

//--- logic/fuc_link.sv
// Byte shifter on the link clock with handshake crossings to the system side
`timescale 1ns/1ps
`include "fuc_params.svh"
module fuc_link (
  // Link clock domain
  input  wire logic       sck,
  input  wire logic       link_frame,
  input  wire logic       sdi,
  output logic            sdo,
  // Reset from the system side
  input  wire logic       rst_b,
  // Reply byte from the system side
  input  wire logic [7:0] tx_hold,
  input  wire logic       tx_tog,
  // Received byte to the system side
  output logic [7:0]      rx_byte,
  output logic            rx_tog
);
  import fuc_pkg::*;

  fuc_link_t r;
  fuc_link_t next_r;

  // Shift one bit per rising link edge inside a frame, LSB first
  always_comb begin
    next_r     = r;
    next_r.rs1 = rst_b;
    next_r.rs2 = r.rs1;
    next_r.t1  = tx_tog;
    next_r.t2  = r.t1;
    next_r.t3  = r.t2;
    if (!link_frame) begin
      // Between frames the count restarts, so a broken frame cannot skew the next
      next_r.cnt   = 3'h0;
      next_r.tx_sh = r.pend ? r.tx_next : `FUC_BYTE_IDLE;
      next_r.ld    = r.pend;
    end else begin
      if (r.cnt == 3'h0 && r.ld) begin
        next_r.pend = 1'b0;
      end
      next_r.rx_sh = {sdi, r.rx_sh[7:1]};                      // RULE_01
      next_r.tx_sh = {1'b1, r.tx_sh[7:1]};
      next_r.cnt   = r.cnt + 3'h1;
      if (r.cnt == 3'h7) begin
        next_r.rx_byte = {sdi, r.rx_sh[7:1]};                  // RULE_01
        next_r.rx_tog  = ~r.rx_tog;
      end
    end
    // A new reply after the clear above still wins
    if (r.t2 ^ r.t3) begin
      next_r.tx_next = tx_hold;
      next_r.pend    = 1'b1;
    end
    if (!r.rs2) begin
      next_r       = '0;
      next_r.rs1   = rst_b;
      next_r.rs2   = r.rs1;
      next_r.tx_sh = `FUC_BYTE_IDLE;
    end
  end

  // Single register stage on the link clock
  always_ff @(posedge sck) begin
    r <= next_r;
  end

  assign sdo     = r.tx_sh[0];
  assign rx_byte = r.rx_byte;
  assign rx_tog  = r.rx_tog;
endmodule

//--- logic/fuc_slave.sv
// Flash update command interpreter of the receiving controller
// Summary of operation
// RULE_01 - Exchange 8-bit characters on clocked serial link
// RULE_02 - Sender supplies data; this side writes flash
// RULE_03 - Replies: 0x00 good, 0x01 bad, 0x11 go
// RULE_04 - Sender sends 0x55 on start trigger
// RULE_05 - On 0x55 copy routine to RAM, run there
// RULE_06 - On 0x77 erase the selected flash blocks
// RULE_07 - On 0x88 receive data table, program flash
// RULE_08 - Four 1K blocks, then one 28K block
// RULE_09 - During update: done pin high, busy low
// RULE_10 - After programming: done pin low, busy high
// RULE_11 - After next reset resume normal with new table
// RULE_12 - Ignore stray bytes; answer failure on aborts
`timescale 1ns/1ps
`include "fuc_params.svh"
module fuc_slave #(
  parameter int TMO_CYCLES  = `FUC_TMO_CYCLES,
  parameter int COPY_CYCLES = `FUC_COPY_CYCLES
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Serial link from the sending controller
  input  wire logic              link_sck,
  input  wire logic              link_frame,
  input  wire logic              link_sdi,
  output logic                   link_sdo,
  // Progress pins
  output logic                   done_indicator_pin,
  output logic                   busy_indicator_pin,
  // Execution status
  output logic                   app_run,
  output logic                   copy_active,
  output logic                   ram_exec,
  output logic                   table_updated,
  // Flash array controller
  output fuc_pkg::fuc_flash_req_t fl_req,
  input  wire fuc_pkg::fuc_flash_rsp_t fl_rsp
);
  import fuc_pkg::*;

  fuc_sys_t   r;
  fuc_sys_t   next_r;
  logic [7:0] rx_byte;
  logic       rx_tog;
  logic       got;
  logic [16:0] span_end;

  // Start address of an erase block
  function automatic logic [14:0] blk_base(input logic [2:0] idx);
    logic [14:0] b;
    b = `FUC_FLASH_TOP;
    case (idx)
      3'h0: b = `FUC_EB0_BASE;
      3'h1: b = `FUC_EB1_BASE;
      3'h2: b = `FUC_EB2_BASE;
      3'h3: b = `FUC_EB3_BASE;
      3'h4: b = `FUC_EB4_BASE;
      default: b = `FUC_FLASH_TOP;
    endcase
    return b;
  endfunction

  // Last address of an erase block; the large block runs to the top
  function automatic logic [14:0] blk_limit(input logic [2:0] idx);
    logic [14:0] l;
    l = `FUC_FLASH_TOP;
    if (idx < 3'h4) begin
      l = blk_base(idx + 3'h1) - 15'h0001;
    end
    return l;
  endfunction

  // Link side shifter, crossing by toggles
  fuc_link fuc_link_inst (
    .sck        (link_sck),
    .link_frame (link_frame),
    .sdi        (link_sdi),
    .sdo        (link_sdo),
    .rst_b      (rst_b),
    .tx_hold    (r.tx_hold),
    .tx_tog     (r.tx_tog),
    .rx_byte    (rx_byte),
    .rx_tog     (rx_tog)
  );

  // New byte when the synchronised toggle moves; data is stable by then
  assign got      = r.s2 ^ r.s3;
  assign span_end = {1'b0, r.addr} + {1'b0, r.left[15:8], rx_byte};  // End of table, one past

  // Interpreter next state
  always_comb begin
    next_r          = r;
    next_r.s1       = rx_tog;
    next_r.s2       = r.s1;
    next_r.s3       = r.s2;
    next_r.fl.erase = 1'b0;
    next_r.fl.write = 1'b0;

    // Silence timer, only while the sender owes us bytes
    if (got || !(r.st == ST_ERASE_SEL || r.st == ST_PROG_HDR || r.st == ST_PROG_DATA)) begin
      next_r.tmr = 18'h0_0000;
    end else begin
      next_r.tmr = r.tmr + 18'h0_0001;
    end

    case (r.st)
      ST_NORMAL: begin
        // Anything but the start byte belongs to the application
        if (got && rx_byte == `FUC_BYTE_START) begin             // RULE_12
          next_r.st       = ST_COPY;                              // RULE_05
          next_r.cnt      = 16'(COPY_CYCLES - 1);
          next_r.copy_act = 1'b1;
          next_r.app_run  = 1'b0;
          next_r.done_pin = 1'b1;                                 // RULE_09
          next_r.busy_pin = 1'b0;                                 // RULE_09
        end
      end
      ST_COPY: begin
        // Bytes during the copy are dropped; the sender waits for the go byte
        if (r.cnt == 16'h0000) begin
          next_r.copy_act = 1'b0;
          next_r.ram_exec = 1'b1;                                 // RULE_05
          next_r.st       = ST_CMD;
          next_r.tx_hold  = `FUC_BYTE_REQ;                        // RULE_03
          next_r.tx_tog   = ~r.tx_tog;
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      ST_CMD: begin
        if (got) begin
          case (rx_byte)
            `FUC_BYTE_ERASE: next_r.st = ST_ERASE_SEL;            // RULE_06
            `FUC_BYTE_PROG: begin
              next_r.st  = ST_PROG_HDR;                           // RULE_07
              next_r.hdr = 2'h0;
            end
            default: begin
              next_r.tx_hold = `FUC_BYTE_NG;                      // RULE_12
              next_r.tx_tog  = ~r.tx_tog;
            end
          endcase
        end
      end
      ST_ERASE_SEL: begin
        // One byte, one bit per block; upper bits are ignored
        if (got) begin
          next_r.mask = rx_byte[4:0];                             // RULE_06
          next_r.blk  = 3'h0;
          next_r.st   = ST_ERASE;
        end
      end
      ST_ERASE: begin
        // Walk the mask so several blocks go in one command
        if (r.blk == 3'(`FUC_NUM_BLOCKS)) begin
          next_r.st      = ST_CMD;
          next_r.tx_hold = `FUC_BYTE_OK;                          // RULE_03
          next_r.tx_tog  = ~r.tx_tog;
        end else if (r.mask[r.blk]) begin
          next_r.fl.erase = 1'b1;                                 // RULE_06
          next_r.fl.addr  = blk_base(r.blk);                      // RULE_08
          next_r.fl.limit = blk_limit(r.blk);                     // RULE_08
          next_r.st       = ST_ERASE_WAIT;
        end else begin
          next_r.blk = r.blk + 3'h1;
        end
      end
      ST_ERASE_WAIT: begin
        if (fl_rsp.done) begin
          if (fl_rsp.fail) begin
            next_r.st      = ST_CMD;
            next_r.tx_hold = `FUC_BYTE_NG;                        // RULE_12
            next_r.tx_tog  = ~r.tx_tog;
          end else begin
            next_r.blk = r.blk + 3'h1;
            next_r.st  = ST_ERASE;
          end
        end
      end
      ST_PROG_HDR: begin
        // Header: address high, address low, size high, size low
        if (got) begin
          next_r.hdr = r.hdr + 2'h1;
          case (r.hdr)
            2'h0: next_r.addr[15:8] = rx_byte;
            2'h1: next_r.addr[7:0]  = rx_byte;
            2'h2: next_r.left[15:8] = rx_byte;
            default: begin
              next_r.left[7:0] = rx_byte;
              // A table that runs past the top of flash is refused whole
              if (span_end > `FUC_FLASH_END) begin
                next_r.st      = ST_CMD;
                next_r.tx_hold = `FUC_BYTE_NG;                    // RULE_12
                next_r.tx_tog  = ~r.tx_tog;
              end else if ({r.left[15:8], rx_byte} == 16'h0000) begin
                next_r.st       = ST_FINISH;
                next_r.tx_hold  = `FUC_BYTE_OK;                   // RULE_03
                next_r.tx_tog   = ~r.tx_tog;
                next_r.done_pin = 1'b0;                           // RULE_10
                next_r.busy_pin = 1'b1;                           // RULE_10
                next_r.ram_exec = 1'b0;
                next_r.updated  = 1'b1;
              end else begin
                next_r.st = ST_PROG_DATA;
              end
            end
          endcase
        end
      end
      ST_PROG_DATA: begin
        if (got) begin
          next_r.fl.write = 1'b1;                                 // RULE_02
          next_r.fl.addr  = r.addr[14:0];                         // RULE_07
          next_r.fl.data  = rx_byte;
          next_r.st       = ST_PROG_WAIT;
        end
      end
      ST_PROG_WAIT: begin
        // Bytes that arrive here are lost: flash must finish within a character
        if (fl_rsp.done) begin
          next_r.addr = r.addr + 16'h0001;
          next_r.left = r.left - 16'h0001;
          if (fl_rsp.fail) begin
            next_r.st      = ST_CMD;
            next_r.tx_hold = `FUC_BYTE_NG;                        // RULE_12
            next_r.tx_tog  = ~r.tx_tog;
          end else if (r.left == 16'h0001) begin
            next_r.st       = ST_FINISH;
            next_r.tx_hold  = `FUC_BYTE_OK;                       // RULE_03
            next_r.tx_tog   = ~r.tx_tog;
            next_r.done_pin = 1'b0;                               // RULE_10
            next_r.busy_pin = 1'b1;                               // RULE_10
            next_r.ram_exec = 1'b0;
            next_r.updated  = 1'b1;
          end else begin
            next_r.st = ST_PROG_DATA;
          end
        end
      end
      ST_FINISH: begin
        // Held until reset, which restarts the application on the new table
        next_r.st = ST_FINISH;                                    // RULE_11
      end
      default: begin
        next_r.st = ST_NORMAL;
      end
    endcase

    // Sender gone quiet mid-transfer: give up and report failure
    if (r.tmr == 18'(TMO_CYCLES - 1)) begin
      next_r.st      = ST_CMD;
      next_r.tx_hold = `FUC_BYTE_NG;                              // RULE_12
      next_r.tx_tog  = ~r.tx_tog;
    end

    if (!rst_b) begin
      next_r          = '0;
      next_r.st       = ST_NORMAL;                                // RULE_11
      next_r.app_run  = 1'b1;
      next_r.busy_pin = 1'b1;
    end
  end

  // Single register stage on the system clock
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // Outputs straight from state flops
  assign done_indicator_pin = r.done_pin;
  assign busy_indicator_pin = r.busy_pin;
  assign app_run            = r.app_run;
  assign copy_active        = r.copy_act;
  assign ram_exec           = r.ram_exec;
  assign table_updated      = r.updated;
  assign fl_req             = r.fl;
endmodule

//--- sim/fuc_slave_asserts.sv
// Concurrent checks on the ports of the flash update command slave
`timescale 1ns/1ps
module fuc_slave_asserts #(
  parameter int COPY_CYCLES = 256
) (
  // System clock and reset
  input wire logic                    clk,
  input wire logic                    rst_b,
  // Progress pins and status
  input wire logic                    done_indicator_pin,
  input wire logic                    busy_indicator_pin,
  input wire logic                    app_run,
  input wire logic                    copy_active,
  input wire logic                    ram_exec,
  input wire logic                    table_updated,
  // Flash request port
  input wire fuc_pkg::fuc_flash_req_t fl_req
);
  import fuc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Copy length counter; cleared whenever the copy is not running
  logic [15:0] copy_n;
  logic        fl_go;
  assign fl_go = fl_req.erase | fl_req.write;
  always_ff @(posedge clk) begin
    if (!rst_b || !copy_active) begin
      copy_n <= '0;
    end else begin
      copy_n <= copy_n + 16'h0001;
    end
  end
  property p_pins_opposite; done_indicator_pin != busy_indicator_pin; endproperty
  a_pins_opposite: assert property (p_pins_opposite)
    else $error("indicator pins agree");
  property p_update_pins; (copy_active || ram_exec) |-> done_indicator_pin && !busy_indicator_pin;
  endproperty
  a_update_pins: assert property (p_update_pins)
    else $error("pins wrong during update");
  property p_finish; $rose(table_updated) |-> busy_indicator_pin && !ram_exec; endproperty
  a_finish: assert property (p_finish)
    else $error("pins wrong after programming");
  property p_updated_hold; table_updated |=> table_updated; endproperty
  a_updated_hold: assert property (p_updated_hold)
    else $error("update flag dropped");
  property p_copy_len; $fell(copy_active) |-> copy_n == COPY_CYCLES && ram_exec; endproperty
  a_copy_len: assert property (p_copy_len)
    else $error("copy length or hand-off wrong");
  property p_start; $fell(app_run) |-> ##[0:1] copy_active; endproperty
  a_start: assert property (p_start)
    else $error("start without copy");
  property p_normal_quiet; app_run |-> !fl_go && !done_indicator_pin && !ram_exec; endproperty
  a_normal_quiet: assert property (p_normal_quiet)
    else $error("activity in normal operation");
  property p_flash_ctx; fl_go |-> ram_exec ##1 !fl_go; endproperty
  a_flash_ctx: assert property (p_flash_ctx)
    else $error("flash request outside update or too long");
  property p_erase_map;
    fl_req.erase |-> (fl_req.addr == 15'h0000 && fl_req.limit == 15'h03FF)
      || (fl_req.addr == 15'h0400 && fl_req.limit == 15'h07FF)
      || (fl_req.addr == 15'h0800 && fl_req.limit == 15'h0BFF)
      || (fl_req.addr == 15'h0C00 && fl_req.limit == 15'h0FFF)
      || (fl_req.addr == 15'h1000 && fl_req.limit == 15'h7FFF);
  endproperty
  a_erase_map: assert property (p_erase_map)
    else $error("erase range not a block");
  // Main scenarios reached
  c_copy: cover property ($rose(copy_active));
  c_erase: cover property (fl_req.erase);
  c_write: cover property (fl_req.write);
  c_done: cover property ($rose(table_updated));
endmodule

//--- sim/fuc_sender.sv
// Behavioural sending controller: makes the link clock and shifts characters
`timescale 1ns/1ps
module fuc_sender (
  // Link to the slave
  output logic      link_sck,
  output logic      link_frame,
  output logic      link_sdi,
  input wire logic  link_sdo
);
  // Clock stands still until a task runs it
  initial begin
    link_sck = 1'b0;
    link_frame = 1'b0;
    link_sdi = 1'b1;
  end
  // Edges with no frame; the slave loads replies only then
  task automatic pulse(input int n);
    repeat (n) begin
      #6 link_sck = 1'b1;
      #6 link_sck = 1'b0;
    end
  endtask
  // One full-duplex character, LSB first; this side is the data source
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    pulse(10);
    link_frame = 1'b1;
    for (int i = 0; i < 8; i++) begin
      link_sdi = tx[i];
      #6 rx[i] = link_sdo;
      link_sck = 1'b1;
      #6 link_sck = 1'b0;
    end
    link_frame = 1'b0;
    // Released data line must not keep looking valid
    link_sdi = ~link_sdi;
  endtask
endmodule

//--- sim/fuc_slave_bench.sv
// Self-checking bench for the flash update command slave
`timescale 1ns/1ps
`include "fuc_params.svh"
module fuc_slave_bench;
  import fuc_pkg::*;
  localparam int TMO = 2000;
  localparam int COPY = 8;
  logic           clk, rst_b, link_sck, link_frame, link_sdi, link_sdo;
  logic           done_pin, busy_pin, app_run, copy_active, ram_exec, table_updated;
  fuc_flash_req_t fl_req;
  fuc_flash_rsp_t fl_rsp;
  logic [7:0]     want;
  int             n_mismatch = 0;
  int             n_tests = 0;
  int             n_cycles = 0;
  logic [14:0]    base [5] = '{`FUC_EB0_BASE, `FUC_EB1_BASE, `FUC_EB2_BASE, `FUC_EB3_BASE,
                               `FUC_EB4_BASE};
  logic [14:0]    top [5] = '{15'h03FF, 15'h07FF, 15'h0BFF, 15'h0FFF, `FUC_FLASH_TOP};
  // Short counts keep the run brief
  fuc_slave #(.TMO_CYCLES(TMO), .COPY_CYCLES(COPY)) fuc_slave_inst (
    .clk(clk), .rst_b(rst_b), .link_sck(link_sck), .link_frame(link_frame),
    .link_sdi(link_sdi), .link_sdo(link_sdo), .done_indicator_pin(done_pin),
    .busy_indicator_pin(busy_pin), .app_run(app_run), .copy_active(copy_active),
    .ram_exec(ram_exec), .table_updated(table_updated), .fl_req(fl_req), .fl_rsp(fl_rsp));
  fuc_sender fuc_sender_inst (
    .link_sck(link_sck), .link_frame(link_frame), .link_sdi(link_sdi), .link_sdo(link_sdo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    n_cycles++;
    if (n_cycles == 10000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Link edges during reset let the link side see it too
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    fork
      fuc_sender_inst.pulse(5);
      repeat (8) @(posedge clk);
    join
    rst_b <= 1'b1;
  endtask
  // One character; the reply seen belongs to the previous command
  task automatic xf(input logic [7:0] tx, input logic [7:0] exp);
    logic [7:0] rx;
    fuc_sender_inst.xfer(tx, rx);
    chk(rx, exp);
  endtask
  // Bounded wait: 0 copy, 1 ram run, 2 flash request, 3 update done
  task automatic wait_on(input int sel);
    int k;
    k = 0;
    while (!(sel == 0 ? copy_active === 1'b1 : sel == 1 ? ram_exec === 1'b1 :
             sel == 2 ? (fl_req.erase | fl_req.write) === 1'b1 : table_updated === 1'b1)
           && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk(k < 5000, 1'b1);
  endtask
  // Flash controller answer a little later, one-cycle done
  task automatic ack(input logic fail);
    repeat (3) @(posedge clk);
    fl_rsp <= '{done: 1'b1, fail: fail};
    @(posedge clk);
    fl_rsp <= '0;
  endtask
  task automatic hdr(input logic [15:0] a, input logic [15:0] s);
    xf(`FUC_BYTE_PROG, want);
    xf(a[15:8], 8'hFF);
    xf(a[7:0], 8'hFF);
    xf(s[15:8], 8'hFF);
    xf(s[7:0], 8'hFF);
  endtask
  task automatic t_stray();
    chk({done_pin, busy_pin, app_run, copy_active, ram_exec, table_updated}, 6'b011000);
    chk(fl_req, '0);
    xf(`FUC_BYTE_ERASE, 8'hFF);
    xf(`FUC_BYTE_PROG, 8'hFF);
    xf(`FUC_BYTE_OK, 8'hFF);
    chk(app_run, 1'b1);
  endtask
  task automatic t_start();
    xf(`FUC_BYTE_START, 8'hFF);
    wait_on(0);
    chk({done_pin, busy_pin, app_run}, 3'b100);
    wait_on(1);
    // Unknown command also fetches the go-ahead byte
    xf(8'h33, `FUC_BYTE_REQ);
    want = `FUC_BYTE_NG;
  endtask
  task automatic t_erase();
    fuc_flash_req_t r;
    for (int i = 0; i < 5; i++) begin
      xf(`FUC_BYTE_ERASE, want);
      xf(8'hE0 | (8'h01 << i), 8'hFF);
      wait_on(2);
      r = fl_req;
      ack(i == 2);
      chk({r.erase, r.addr}, {1'b1, base[i]});
      chk(r.limit, top[i]);
      want = (i == 2) ? `FUC_BYTE_NG : `FUC_BYTE_OK;
    end
    // Two blocks in one command: first small block and the large one
    xf(`FUC_BYTE_ERASE, want);
    xf(8'h11, 8'hFF);
    for (int j = 0; j < 5; j += 4) begin
      wait_on(2);
      r = fl_req;
      ack(1'b0);
      chk({r.erase, r.addr, r.limit}, {1'b1, base[j], top[j]});
    end
    want = `FUC_BYTE_OK;
  endtask
  // One byte past the top of flash is refused, then silence aborts
  task automatic t_refuse();
    hdr(16'h7FFF, 16'h0002);
    want = `FUC_BYTE_NG;
    xf(`FUC_BYTE_ERASE, want);
    repeat (TMO + 100) @(negedge clk);
    want = `FUC_BYTE_NG;
  endtask
  task automatic t_program();
    fuc_flash_req_t r;
    logic [7:0]     dat [2] = '{8'hAB, 8'h5C};
    hdr(16'h7FFE, 16'h0002);
    for (int i = 0; i < 2; i++) begin
      xf(dat[i], 8'hFF);
      wait_on(2);
      r = fl_req;
      ack(1'b0);
      chk({r.write, r.addr}, {1'b1, 15'h7FFE + 15'(i)});
      chk(r.data, dat[i]);
    end
    wait_on(3);
    chk({done_pin, busy_pin, ram_exec}, 3'b010);
    xf(8'hFF, `FUC_BYTE_OK);
  endtask
  task automatic t_again();
    do_reset();
    chk({done_pin, busy_pin, app_run, ram_exec}, 4'b0110);
    xf(`FUC_BYTE_START, 8'hFF);
    wait_on(0);
    wait_on(1);
    // Empty table finishes at once
    want = `FUC_BYTE_REQ;
    hdr(16'h0010, 16'h0000);
    wait_on(3);
    chk({done_pin, busy_pin, table_updated}, 3'b011);
    xf(8'hFF, `FUC_BYTE_OK);
  endtask
  initial begin
    rst_b = 1'b0;
    fl_rsp = '0;
    want = 8'hFF;
    do_reset();
    t_stray();
    t_start();
    t_erase();
    t_refuse();
    t_program();
    t_again();
    wrap_up();
  end
endmodule
bind fuc_slave fuc_slave_asserts #(.COPY_CYCLES(COPY_CYCLES)) fuc_slave_asserts_inst (
  .clk(clk), .rst_b(rst_b), .done_indicator_pin(done_indicator_pin),
  .busy_indicator_pin(busy_indicator_pin), .app_run(app_run), .copy_active(copy_active),
  .ram_exec(ram_exec), .table_updated(table_updated), .fl_req(fl_req));
